/* src/pmbi_map.svh */
// Purpose: constants for the PCI master bus interface unit
// Assumes: included by bare name
// Notes: offsets are word byte addresses on the Wishbone slave
`ifndef PMBI_MAP_SVH
`define PMBI_MAP_SVH
// Register offsets
`define PMBI_OFF_BURST_CTRL 8'h00
`define PMBI_OFF_CTRL 8'h04
`define PMBI_OFF_CMD_REG 8'h08
`define PMBI_OFF_STATUS 8'h0C
`define PMBI_OFF_ADDR 8'h10
`define PMBI_OFF_WDATA 8'h14
`define PMBI_OFF_RDATA 8'h18
`define PMBI_OFF_XFER 8'h1C
// Field positions
`define PMBI_BIT_BREAD_EN 6
`define PMBI_BIT_EXT_REQ 8
`define PMBI_BIT_RD_CMD_SEL 9
`define PMBI_BIT_HALT 2
`define PMBI_BIT_SUSPEND 0
`define PMBI_BIT_ADDRESS_STEPPING_FLAG 7
`define PMBI_BIT_SW_RESET 31
// Reset values
`define PMBI_RST_BURST_CTRL 32'h0000_0000
// PCI command codes and data phase byte enables
`define PMBI_CMD_MEM_RD 4'h6
`define PMBI_CMD_MEM_WR 4'h7
`define PMBI_CMD_MEM_RD_MULT 4'hC
`define PMBI_CMD_MEM_RD_LINE 4'hE
`define PMBI_BE_ALL_N 4'h0
`endif

/* src/pmbi_pkg.sv */
// Purpose: types for the PCI master bus interface unit
// Assumes: nothing
// Notes: state and target kinds
package pmbi_pkg;
    typedef enum logic [1:0] {
        PMBI_TGT_INIT,
        PMBI_TGT_DESC,
        PMBI_TGT_TXBUF,
        PMBI_TGT_RXBUF
    } pmbi_target_t;
    typedef enum logic [2:0] {
        PMBI_ST_IDLE,
        PMBI_ST_REQ,
        PMBI_ST_ADDR,
        PMBI_ST_DATA,
        PMBI_ST_TURN
    } pmbi_state_t;
endpackage : pmbi_pkg

/* src/pmbi_master.sv */
// Purpose: PCI bus master side: arbitration, command choice, single data phase cycles and multi-phase TX buffer burst reads
// Assumes: Wishbone classic slave for control; all PCI pins sampled through two flops
// Notes: burst is modelled as one transaction per ownership with a programmed length
//
// The register addresses and register access over Wishbone are this design's own decisions.
`timescale 1ns/10ps
`include "pmbi_map.svh"
module pmbi_master
    import pmbi_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // PCI arbitration
    output logic req_n_o,
    input wire logic gnt_n_i,
    // PCI control, output enable low while driving
    input wire logic frame_n_i,
    output logic frame_n_o,
    output logic frame_oe_n_o,
    input wire logic irdy_n_i,
    output logic irdy_n_o,
    output logic irdy_oe_n_o,
    input wire logic trdy_n_i,
    input wire logic devsel_n_i,
    // PCI address/data
    input wire logic [31:0] ad_i,
    output logic [31:0] ad_o,
    output logic ad_oe_n_o,
    output logic [3:0] cbe_n_o,
    output logic cbe_oe_n_o,
    output logic par_o,
    output logic par_oe_n_o,
    // Status
    output logic busy_o
);
    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic even_par(input logic [31:0] d, input logic [3:0] c);
        even_par = ^{d, c};
    endfunction : even_par

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] pin_s1;
    logic [4:0] pin_s2;
    logic [31:0] ad_s1;
    logic [31:0] ad_s2;
    always_ff @(posedge clk_i) begin
        pin_s1 <= {gnt_n_i, frame_n_i, irdy_n_i, trdy_n_i, devsel_n_i};
        pin_s2 <= pin_s1;
        ad_s1 <= ad_i;
        ad_s2 <= ad_s1;
    end
    wire gnt = ~pin_s2[4];
    wire bus_idle = pin_s2[3] & pin_s2[2];
    wire trdy = ~pin_s2[1];
    wire devsel = ~pin_s2[0];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0] bus_burst_control_register;
    logic [2:0] controller_status_register;
    logic suspend_request_bit;
    logic [31:0] xfer_addr;
    logic [31:0] xfer_wdata;
    logic [31:0] xfer_rdata;
    logic [3:0] xfer_be;
    logic [1:0] xfer_tgt;
    logic xfer_write;
    logic [7:0] xfer_count;
    logic sw_reset;
    logic go;
    logic no_devsel;
    logic [7:0] done_count;
    pmbi_state_t state;
    pmbi_state_t next_state;

    wire burst_read_enable = bus_burst_control_register[`PMBI_BIT_BREAD_EN];
    wire extended_request_hold = bus_burst_control_register[`PMBI_BIT_EXT_REQ];
    wire burst_read_command_select = bus_burst_control_register[`PMBI_BIT_RD_CMD_SEL];
    wire any_reset = rst_i | sw_reset;
    wire bus_acc = cyc_i & stb_i & ~ack_o;
    wire wr_acc = bus_acc & we_i;
    wire hit_bc = adr_i == `PMBI_OFF_BURST_CTRL;
    wire hit_ctrl = adr_i == `PMBI_OFF_CTRL;
    wire hit_addr = adr_i == `PMBI_OFF_ADDR;
    wire hit_wdata = adr_i == `PMBI_OFF_WDATA;
    wire hit_xfer = adr_i == `PMBI_OFF_XFER;
    wire start_req = wr_acc & hit_xfer & sel_i[0] & (state == PMBI_ST_IDLE);
    wire [31:0] cmd_reg_rd = 32'h0000_0004; // Bus master enable; stepping bit fixed 0

    // Burst is a multi-phase read only when enabled and aimed at TX buffer
    wire is_burst = ~xfer_write & burst_read_enable & (xfer_tgt == 2'(PMBI_TGT_TXBUF));
    wire last_phase = (done_count + 8'h01) >= xfer_count;

    // Command choice
    wire [3:0] rd_cmd = ~is_burst ? `PMBI_CMD_MEM_RD :
        (burst_read_command_select ? `PMBI_CMD_MEM_RD_MULT : `PMBI_CMD_MEM_RD_LINE);
    wire [3:0] cmd = xfer_write ? `PMBI_CMD_MEM_WR : rd_cmd;
    wire [3:0] data_be_n = xfer_write ? ~xfer_be : `PMBI_BE_ALL_N;

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb begin
        unique case (adr_i)
            `PMBI_OFF_BURST_CTRL: rd_mux = bus_burst_control_register;
            `PMBI_OFF_CTRL: rd_mux = {29'h0, controller_status_register[2], 1'b0,
                                      suspend_request_bit};
            `PMBI_OFF_CMD_REG: rd_mux = cmd_reg_rd;
            `PMBI_OFF_STATUS: rd_mux = {21'h0, no_devsel, 2'(state == PMBI_ST_IDLE), done_count};
            `PMBI_OFF_ADDR: rd_mux = xfer_addr;
            `PMBI_OFF_WDATA: rd_mux = xfer_wdata;
            `PMBI_OFF_RDATA: rd_mux = xfer_rdata;
            `PMBI_OFF_XFER: rd_mux = {16'h0, xfer_count, xfer_be, xfer_write, 1'b0, xfer_tgt};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= bus_acc;
            dat_o <= bus_acc ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_burst_control_register <= `PMBI_RST_BURST_CTRL;
            controller_status_register <= 3'h0;
            suspend_request_bit <= 1'b0;
            sw_reset <= 1'b0;
            xfer_addr <= 32'h0000_0000;
            xfer_wdata <= 32'h0000_0000;
            xfer_be <= 4'h0;
            xfer_tgt <= 2'h0;
            xfer_write <= 1'b0;
            xfer_count <= 8'h01;
            go <= 1'b0;
        end else begin
            sw_reset <= wr_acc & hit_ctrl & dat_i[`PMBI_BIT_SW_RESET];
            go <= start_req;
            if (wr_acc & hit_bc) begin
                bus_burst_control_register <= dat_i & 32'h0000_0340;
            end
            if (wr_acc & hit_ctrl) begin
                controller_status_register[2] <= dat_i[`PMBI_BIT_HALT];
                suspend_request_bit <= dat_i[`PMBI_BIT_SUSPEND];
            end
            if (wr_acc & hit_addr) begin
                xfer_addr <= {dat_i[31:2], 2'b00};
            end
            if (wr_acc & hit_wdata) begin
                xfer_wdata <= dat_i;
            end
            if (start_req) begin
                xfer_tgt <= dat_i[1:0];
                xfer_write <= dat_i[3];
                xfer_be <= dat_i[7:4];
                xfer_count <= (dat_i[15:8] == 8'h00) ? 8'h01 : dat_i[15:8];
            end
        end
    end

    // ------------------------------------------------------------
    // Bus master sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            PMBI_ST_IDLE: if (go) next_state = PMBI_ST_REQ;
            PMBI_ST_REQ: if (gnt & bus_idle) next_state = PMBI_ST_ADDR;
            PMBI_ST_ADDR: next_state = PMBI_ST_DATA;
            PMBI_ST_DATA: begin
                if (trdy & (is_burst ? last_phase : 1'b1)) begin
                    next_state = PMBI_ST_TURN;
                end
            end
            PMBI_ST_TURN: begin
                // Counter already holds the finished phase here
                if ((done_count >= xfer_count) | is_burst) begin
                    next_state = PMBI_ST_IDLE;
                end else if (gnt & bus_idle) begin
                    // Own IRDY and a stale TRDY must leave the synchronisers first
                    next_state = PMBI_ST_ADDR;
                end else begin
                    next_state = PMBI_ST_REQ;
                end
            end
        endcase
    end

    // REQ drop points
    wire entering_addr = next_state == PMBI_ST_ADDR;
    wire last_nb_frame = ~is_burst & last_phase & entering_addr;
    wire burst_frame_drop = is_burst & ~extended_request_hold & entering_addr;
    wire burst_last_start = is_burst & extended_request_hold & (state == PMBI_ST_DATA)
        & ((done_count + 8'h02) >= xfer_count) & trdy;
    wire next_req = (state == PMBI_ST_REQ) | ((state != PMBI_ST_IDLE) & ~req_n_o);

    always_ff @(posedge clk_i) begin
        if (any_reset) begin
            state <= PMBI_ST_IDLE;
            req_n_o <= 1'b1;
            frame_n_o <= 1'b1;
            frame_oe_n_o <= 1'b1;
            irdy_n_o <= 1'b1;
            irdy_oe_n_o <= 1'b1;
            ad_o <= 32'h0000_0000;
            ad_oe_n_o <= 1'b1;
            cbe_n_o <= 4'hF;
            cbe_oe_n_o <= 1'b1;
            par_o <= 1'b0;
            par_oe_n_o <= 1'b1;
            done_count <= 8'h00;
            xfer_rdata <= 32'h0000_0000;
            no_devsel <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            state <= next_state;
            busy_o <= next_state != PMBI_ST_IDLE;
            // Halt and suspend bits are deliberately not terms here
            if (next_state == PMBI_ST_REQ && state != PMBI_ST_REQ) begin
                req_n_o <= 1'b0;
            end else if (last_nb_frame | burst_frame_drop | burst_last_start) begin
                req_n_o <= 1'b1;
            end else if (next_state == PMBI_ST_IDLE) begin
                req_n_o <= 1'b1;
            end else begin
                req_n_o <= ~next_req;
            end
            // Parity follows the phase it covers by one clock
            par_o <= even_par(ad_o, cbe_n_o);
            par_oe_n_o <= ad_oe_n_o;
            if (entering_addr) begin
                frame_n_o <= 1'b0;
                frame_oe_n_o <= 1'b0;
                ad_o <= xfer_addr + {22'h0, done_count, 2'b00};
                ad_oe_n_o <= 1'b0;
                cbe_n_o <= cmd;
                cbe_oe_n_o <= 1'b0;
                irdy_oe_n_o <= 1'b0;
                irdy_n_o <= 1'b1;
            end else if (state == PMBI_ST_ADDR) begin
                irdy_n_o <= 1'b0;
                cbe_n_o <= data_be_n;
                ad_o <= xfer_wdata;
                ad_oe_n_o <= ~xfer_write;
                if (~is_burst | last_phase) begin
                    frame_n_o <= 1'b1;
                end
            end else if (state == PMBI_ST_DATA) begin
                if (trdy) begin
                    done_count <= done_count + 8'h01;
                    xfer_rdata <= ad_s2;
                    no_devsel <= ~devsel;
                    if (is_burst & ((done_count + 8'h02) >= xfer_count)) begin
                        frame_n_o <= 1'b1;
                    end
                    if (next_state == PMBI_ST_TURN) begin
                        irdy_n_o <= 1'b1;
                        ad_oe_n_o <= 1'b1;
                        cbe_oe_n_o <= 1'b1;
                    end
                end
            end else begin
                frame_oe_n_o <= 1'b1;
                irdy_oe_n_o <= 1'b1;
                if (state == PMBI_ST_IDLE && go) begin
                    done_count <= 8'h00;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_CMD_LEGAL: assert property (!cbe_oe_n_o && $fell(frame_n_o) |->
        cbe_n_o inside {4'h6, 4'h7, 4'hC, 4'hE}) else $error("illegal command");
    AST_WR_CMD: assert property ($fell(frame_n_o) && xfer_write |->
        cbe_n_o == 4'h7) else $error("write not memory write");
    AST_NB_RD: assert property ($fell(frame_n_o) && !xfer_write && !is_burst |->
        cbe_n_o == 4'h6) else $error("non-burst read command wrong");
    AST_BURST_RD: assert property ($fell(frame_n_o) && is_burst |->
        cbe_n_o == (burst_read_command_select ? 4'hC : 4'hE)) else $error("burst cmd");
    AST_GNT_START: assert property (entering_addr |-> gnt) else $error("start without grant");
    AST_IDLE_START: assert property (entering_addr && state == PMBI_ST_REQ |->
        bus_idle) else $error("start on busy bus");
    AST_ADDRESS_STEPPING_FLAG: assert property (cmd_reg_rd[7] == 1'b0) else $error("stepping set");
    AST_IRDY: assert property (state == PMBI_ST_ADDR |=> !irdy_n_o) else $error("irdy late");
    AST_HOLD: assert property (state == PMBI_ST_DATA && !trdy |=> state == PMBI_ST_DATA)
        else $error("data phase closed early");
    AST_RD_BE: assert property (state == PMBI_ST_DATA && !xfer_write |->
        cbe_n_o == 4'h0) else $error("read lanes off");
    AST_REQ_KEEP: assert property (state == PMBI_ST_REQ && !sw_reset ##1 !gnt && !sw_reset |->
        !req_n_o) else $error("req withdrawn");
    AST_SWRST: assert property (sw_reset |=> req_n_o) else $error("req after reset");
    AST_BURST_REQ: assert property ($fell(frame_n_o) && is_burst && !extended_request_hold |->
        req_n_o) else $error("burst req kept at frame");
    AST_NB_REQ: assert property ($fell(frame_n_o) && !is_burst |->
        req_n_o == last_phase) else $error("non-burst req drop point wrong");
    AST_PAR: assert property (!ad_oe_n_o |=> par_o == even_par($past(ad_o), $past(cbe_n_o)))
        else $error("parity wrong");

    COV_NB_READ: cover property ($fell(frame_n_o) && cbe_n_o == 4'h6);
    COV_WRITE: cover property ($fell(frame_n_o) && cbe_n_o == 4'h7);
    COV_BURST: cover property ($fell(frame_n_o) && is_burst);
    COV_WAIT: cover property (state == PMBI_ST_DATA && !trdy ##1 trdy);
endmodule : pmbi_master

/* bench/pmbi_far_side.sv */
// Purpose: PCI arbiter and memory target facing the master unit
// Assumes: bench resolves FRAME and IRDY wires with pull-ups
// Notes: TRDY held until IRDY rises, as the master sees it two clocks late
`timescale 1ns/10ps
module pmbi_far_side (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Arbitration
    input wire logic req_n_i,
    input wire logic hold_i,
    output logic gnt_n_o,
    // Bus
    input wire logic frame_n_i,
    input wire logic irdy_n_i,
    output logic trdy_n_o,
    output logic devsel_n_o,
    output logic [31:0] ad_o,
    // Target setup
    input wire logic [2:0] wait_i,
    input wire logic [31:0] rdata_i
);
    logic fr_q;
    logic act;
    logic seen;
    logic [2:0] cnt;
    // Released data lines show the inverse, never a stale copy
    assign ad_o = rdata_i ^ {32{trdy_n_o}};
    always_ff @(posedge clk_i) begin
        if (rst_i) gnt_n_o <= 1'b1;
        else gnt_n_o <= req_n_i | hold_i;
    end
    always_ff @(posedge clk_i) begin
        fr_q <= frame_n_i;
        if (rst_i) begin
            act <= 1'b0;
            seen <= 1'b0;
            cnt <= 3'h0;
            trdy_n_o <= 1'b1;
            devsel_n_o <= 1'b1;
        end else if (!act) begin
            if (!frame_n_i && fr_q) begin
                act <= 1'b1;
                seen <= 1'b0;
                cnt <= wait_i;
            end
        end else if (trdy_n_o) begin
            if (cnt == 3'h0) begin
                trdy_n_o <= 1'b0;
                devsel_n_o <= 1'b0;
            end else cnt <= cnt - 3'h1;
        end else begin
            if (!irdy_n_i) seen <= 1'b1;
            if (seen && irdy_n_i) begin
                act <= 1'b0;
                trdy_n_o <= 1'b1;
                devsel_n_o <= 1'b1;
            end
        end
    end
endmodule : pmbi_far_side

/* bench/tb_top.sv */
// Purpose: self-checking bench for the PCI master unit
// Assumes: Wishbone classic control, one clock domain
// Notes: bus wires watched directly for command, byte lanes and REQ
`timescale 1ns/10ps
`include "pmbi_map.svh"
module tb_top;
    logic clk_i, rst_i, cyc, stb, we, hold;
    logic [7:0] adr;
    logic [31:0] wdat, dat_o, ad_o, ad_far, v;
    logic ack_o, req_n_o, gnt_n, frame_n_o, frame_oe_n_o, irdy_n_o, irdy_oe_n_o;
    logic trdy_n, devsel_n, ad_oe_n_o, cbe_oe_n_o, par_o, par_oe_n_o, busy_o;
    logic [3:0] cbe_n_o, last_cmd, last_be;
    logic [2:0] wait_c;
    logic fr_d, last_req;
    logic [31:0] last_adr, p_ad;
    logic [3:0] p_cbe;
    int n_addr, n0, n_fail, total_checks;
    localparam logic [31:0] RD_PAT = 32'hA5C3_0F96;
    wire frame_w = frame_oe_n_o ? 1'b1 : frame_n_o;
    wire irdy_w = irdy_oe_n_o ? 1'b1 : irdy_n_o;
    wire [31:0] ad_w = ad_oe_n_o ? ad_far : ad_o;
    pmbi_master dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
        .req_n_o(req_n_o), .gnt_n_i(gnt_n), .frame_n_i(frame_w), .frame_n_o(frame_n_o),
        .frame_oe_n_o(frame_oe_n_o), .irdy_n_i(irdy_w), .irdy_n_o(irdy_n_o),
        .irdy_oe_n_o(irdy_oe_n_o), .trdy_n_i(trdy_n), .devsel_n_i(devsel_n), .ad_i(ad_w),
        .ad_o(ad_o), .ad_oe_n_o(ad_oe_n_o), .cbe_n_o(cbe_n_o), .cbe_oe_n_o(cbe_oe_n_o),
        .par_o(par_o), .par_oe_n_o(par_oe_n_o), .busy_o(busy_o));
    pmbi_far_side far (.clk_i(clk_i), .rst_i(rst_i), .req_n_i(req_n_o), .hold_i(hold),
        .gnt_n_o(gnt_n), .frame_n_i(frame_w), .irdy_n_i(irdy_w), .trdy_n_o(trdy_n),
        .devsel_n_o(devsel_n), .ad_o(ad_far), .wait_i(wait_c), .rdata_i(RD_PAT));
    always #5 clk_i = ~clk_i;
    // Bus monitor: address phase is the first clock of FRAME low
    always @(posedge clk_i) begin
        if (!frame_w && fr_d) begin
            n_addr++;
            last_cmd = cbe_n_o;
            last_adr = ad_o;
            last_req = req_n_o;
        end
        if (!irdy_w) last_be = cbe_n_o;
        // Parity stands one clock after the phase it covers
        if (!par_oe_n_o) chk({31'h0, par_o}, {31'h0, ^{p_ad, p_cbe}});
        p_ad = ad_o;
        p_cbe = cbe_n_o;
        fr_d = frame_w;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (ack_o !== 1'b1) n_fail++;
        v = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task start(input logic [1:0] tgt, input logic wr, input logic [3:0] be,
        input logic [7:0] cnt);
        wb(`PMBI_OFF_XFER, 1'b1, {16'h0000, cnt, be, wr, 1'b0, tgt});
    endtask : start
    task wait_idle;
        int n;
        n = 0;
        repeat (3) @(posedge clk_i);
        while (busy_o !== 1'b0 && n < 500) begin
            @(posedge clk_i);
            n++;
        end
        chk({31'h0, busy_o}, 32'h0);
    endtask : wait_idle
    task t_regs;
        wb(`PMBI_OFF_BURST_CTRL, 1'b0, 32'h0);
        chk(v, `PMBI_RST_BURST_CTRL);
        wb(`PMBI_OFF_CMD_REG, 1'b1, 32'hFFFF_FFFF);
        wb(`PMBI_OFF_CMD_REG, 1'b0, 32'h0);
        chk(v, 32'h0000_0004);
        wb(8'h20, 1'b1, 32'hFFFF_FFFF);
        wb(8'h20, 1'b0, 32'h0);
        chk(v, 32'h0);
        wb(`PMBI_OFF_BURST_CTRL, 1'b1, 32'hFFFF_FFFF);
        wb(`PMBI_OFF_BURST_CTRL, 1'b0, 32'h0);
        chk(v, 32'h0000_0340);
    endtask : t_regs
    task one_case(input logic [31:0] bc, input logic [1:0] tgt, input logic wr,
        input logic [3:0] be, input logic [3:0] cmd, input logic [3:0] ben, input logic rq);
        wb(`PMBI_OFF_BURST_CTRL, 1'b1, bc);
        wb(`PMBI_OFF_ADDR, 1'b1, 32'h0000_2000);
        n0 = n_addr;
        start(tgt, wr, be, 8'h01);
        wait_idle();
        chk(n_addr - n0, 32'd1);
        chk({28'h0, last_cmd}, {28'h0, cmd});
        chk({28'h0, last_be}, {28'h0, ben});
        chk(last_adr, 32'h0000_2000);
        chk({31'h0, last_req}, {31'h0, rq});
        if (!wr) begin
            wb(`PMBI_OFF_RDATA, 1'b0, 32'h0);
            chk(v, RD_PAT);
        end
    endtask : one_case
    task t_cmds;
        wait_c <= 3'h2;
        one_case(32'h0, 2'd0, 1'b0, 4'h0, 4'h6, 4'h0, 1'b1);
        one_case(32'h0, 2'd1, 1'b0, 4'h0, 4'h6, 4'h0, 1'b1);
        one_case(32'h0, 2'd2, 1'b0, 4'h0, 4'h6, 4'h0, 1'b1);
        one_case(32'h200, 2'd2, 1'b0, 4'h0, 4'h6, 4'h0, 1'b1);
        one_case(32'h40, 2'd2, 1'b0, 4'h0, 4'hE, 4'h0, 1'b1);
        one_case(32'h240, 2'd2, 1'b0, 4'h0, 4'hC, 4'h0, 1'b1);
        one_case(32'h140, 2'd2, 1'b0, 4'h0, 4'hE, 4'h0, 1'b0);
        one_case(32'h40, 2'd0, 1'b0, 4'h0, 4'h6, 4'h0, 1'b1);
        one_case(32'h0, 2'd1, 1'b1, 4'h3, 4'h7, 4'hC, 1'b1);
        one_case(32'h0, 2'd3, 1'b1, 4'hA, 4'h7, 4'h5, 1'b1);
    endtask : t_cmds
    task t_multi;
        wait_c <= 3'h0;
        wb(`PMBI_OFF_BURST_CTRL, 1'b1, 32'h0);
        n0 = n_addr;
        start(2'd0, 1'b0, 4'h0, 8'h03);
        wait_idle();
        chk(n_addr - n0, 32'd3);
        wb(`PMBI_OFF_STATUS, 1'b0, 32'h0);
        chk({21'h0, v[10:0]}, 32'h0000_0103);
        chk({31'h0, last_req}, 32'h1);
    endtask : t_multi
    task t_grant_wait;
        hold <= 1'b1;
        n0 = n_addr;
        start(2'd1, 1'b0, 4'h0, 8'h01);
        repeat (20) @(posedge clk_i);
        chk({31'h0, req_n_o}, 32'h0);
        chk(n_addr, n0);
        wb(`PMBI_OFF_CTRL, 1'b1, 32'h0000_0005);
        repeat (5) @(posedge clk_i);
        chk({31'h0, req_n_o}, 32'h0);
        wb(`PMBI_OFF_CTRL, 1'b1, 32'h0);
        hold <= 1'b0;
        wait_idle();
        chk(n_addr, n0 + 1);
    endtask : t_grant_wait
    task t_swreset;
        hold <= 1'b1;
        n0 = n_addr;
        start(2'd1, 1'b0, 4'h0, 8'h01);
        repeat (10) @(posedge clk_i);
        chk({31'h0, req_n_o}, 32'h0);
        wb(`PMBI_OFF_CTRL, 1'b1, 32'h8000_0000);
        repeat (2) @(posedge clk_i);
        chk({31'h0, req_n_o}, 32'h1);
        wb(`PMBI_OFF_CTRL, 1'b1, 32'h0);
        hold <= 1'b0;
        repeat (20) @(posedge clk_i);
        chk(n_addr, n0);
        chk({31'h0, busy_o}, 32'h0);
    endtask : t_swreset
    task t_hwreset;
        hold <= 1'b1;
        n0 = n_addr;
        start(2'd1, 1'b0, 4'h0, 8'h01);
        repeat (5) @(posedge clk_i);
        chk({31'h0, req_n_o}, 32'h0);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk({31'h0, req_n_o}, 32'h1);
        rst_i <= 1'b0;
        hold <= 1'b0;
        repeat (20) @(posedge clk_i);
        chk(n_addr, n0);
        chk({31'h0, busy_o}, 32'h0);
        wb(`PMBI_OFF_BURST_CTRL, 1'b0, 32'h0);
        chk(v, `PMBI_RST_BURST_CTRL);
    endtask : t_hwreset
    task conclude;
        if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude
    // Whole sequence needs well under a thousand clocks; the limit of 30000 clocks is ample
    initial begin
        #300000;
        n_fail++;
        conclude();
    end
    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        wdat = 32'h0;
        hold = 1'b0;
        wait_c = 3'h0;
        fr_d = 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_cmds();
        t_multi();
        t_grant_wait();
        t_swreset();
        t_hwreset();
        conclude();
    end
endmodule : tb_top
